// file: hdl/oc_delay_timer.v
// Purpose: retry and delay timer counting 2^n delay time units
// Assumes: unit length is given in system clock cycles by the time-unit register
// Notes:   a load restarts the interval; done is a one-cycle pulse at its end
`timescale 1ns/1ns
`include "oc_fault_regs.vh"

// =====================================================================
// delay timer
module oc_delay_timer (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [2:0] exponent,
  input wire [15:0] unit_cycles,
  output wire busy,
  output reg done
);

  reg [15:0] cycle_cnt; // cycles inside the current unit
  reg [7:0] units_left; // whole units still to run
  wire unit_tick; // one-cycle enable at the end of each unit

  // number of units for a field value: 1, 2, 4 .. 128
  function [7:0] units_of;
    input [2:0] code;
    begin
      units_of = `UNITS_ONE << code;
    end
  endfunction

  // a unit of zero would never tick, so it is treated as a one-cycle unit
  assign unit_tick = (cycle_cnt + `UNIT_ONE >= unit_cycles);
  assign busy = (units_left != `RST_UNITS);

  // unit divider and unit countdown, reloaded on every load
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cycle_cnt <= `RST_WORD;
      units_left <= `RST_UNITS;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cycle_cnt <= `RST_WORD;
        units_left <= units_of(exponent);
      end else if (busy) begin
        if (unit_tick) begin
          cycle_cnt <= `RST_WORD;
          units_left <= units_left - `UNITS_ONE;
          if (units_left == `UNITS_ONE) begin
            done <= 1'b1;
          end
        end else begin
          cycle_cnt <= cycle_cnt + `UNIT_ONE;
        end
      end
    end
  end

endmodule // oc_delay_timer

// file: hdl/oc_fault_regs.vh
// Purpose: command codes, field positions, reset values and state codes of the
//          over-current fault response block
// Assumes: one 100 MHz system clock; command port carries one command per strobe
// Notes:   definitions only, included by the main module and the delay timer
`ifndef OC_FAULT_REGS_VH
`define OC_FAULT_REGS_VH

// =====================================================================
// command codes
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_OC_LIMIT 8'h46
`define CMD_OC_RESPONSE 8'h47
`define CMD_STATUS_CURRENT 8'h7b
`define CMD_TIME_UNIT 8'hd2

// =====================================================================
// field positions of the response byte
`define RESP_MODE_HI 7
`define RESP_MODE_LO 6
`define RESP_RETRY_HI 5
`define RESP_RETRY_LO 3
`define RESP_TIME_HI 2
`define RESP_TIME_LO 0

// response codes
`define MODE_IGNORE 2'h0
`define MODE_COND_CC 2'h1
`define MODE_DELAY_CC 2'h2
`define MODE_SHUTDOWN 2'h3

// retry codes
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7

// status byte: over-current fault bit
`define STATUS_OC_BIT 7

// =====================================================================
// reset values
`define RST_OC_LIMIT 16'h0000
`define RST_OC_RESPONSE 8'hc0
`define RST_TIME_UNIT 16'h0064
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_RETRY_CNT 3'h0
`define RST_UNITS 8'h00

// =====================================================================
// sizes and small constants
`define UNIT_ONE 16'h0001
`define UNITS_ONE 8'h01
`define COUNT_ONE 3'h1

// =====================================================================
// controller states
`define ST_OFF 3'h0
`define ST_RUN 3'h1
`define ST_DELAY 3'h2
`define ST_WAIT 3'h3
`define ST_LATCHED 3'h4

`endif

// file: hdl/oc_fault_response.v
// Purpose: output over-current fault response controller with its command registers
// Assumes: over-current, low-voltage, remote-control and bias-good arrive as pins;
//          the operation on/off state and other-fault shutdown come from same-clock logic
// Notes:   the analog current limit itself lives outside; this block only enables it
`timescale 1ns/1ns
`include "oc_fault_regs.vh"

// =====================================================================
module oc_fault_response (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire [7:0] CMD_CODE,
  input wire [15:0] WR_DATA,
  input wire WR_STB,
  input wire RD_STB,
  output reg [15:0] RD_DATA,
  output reg RD_VALID,
  input wire OC_DETECT,
  input wire VOUT_BELOW_LV,
  input wire CTRL_ON,
  input wire BIAS_OK,
  input wire OPERATION_ON,
  input wire OTHER_FAULT,
  output reg OUTPUT_EN,
  output reg CC_LIMIT_EN,
  output reg [15:0] OC_LIMIT,
  output reg OC_FAULT_FLAG,
  output reg ALERT_N
);

  // =====================================================================
  // registers and internal state
  reg [7:0] oc_response; // response byte: mode, retries, time
  reg [15:0] time_unit; // length of one delay unit in system cycles
  reg [2:0] state; // controller state
  reg [2:0] next_state; // combinational next state
  reg [2:0] retry_cnt; // restart attempts made since the fault
  reg probation; // a restart is running, not yet proven good
  reg timer_load; // combinational timer reload request
  reg count_retry; // combinational: a restart attempt starts now
  reg clear_retry; // combinational: retry counter goes back to zero
  wire [3:0] pins; // synchronised pin levels
  wire oc_now; // over-current seen by the sensor
  wire vout_low; // output below the low-voltage floor
  wire ctrl_on; // remote control pin asks for on
  wire bias_ok; // bias supply good
  wire enabled; // output is commanded on and may run
  wire [1:0] mode; // response code
  wire [2:0] retry_set; // retry code
  wire timer_busy; // delay interval running
  wire timer_done; // delay interval ended
  wire wr_clear_faults; // clear-faults command
  wire wr_status_clear; // write-one to the over-current status bit
  wire fault_clear; // either host command that clears the latched fault
  wire oc_event; // over-current seen while the output runs

  // =====================================================================
  // pin inputs: three stages plus a filter flop each, pins are not on this clock
  pin_sync3 #(
    .WIDTH(4)
  ) u_pins (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_in({BIAS_OK, CTRL_ON, VOUT_BELOW_LV, OC_DETECT}),
    .level(pins)
  );

  assign oc_now = pins[0];
  assign vout_low = pins[1];
  assign ctrl_on = pins[2];
  assign bias_ok = pins[3];

  // on needs both controls and bias; losing any of them drops the output
  assign enabled = ctrl_on & OPERATION_ON & bias_ok & ~OTHER_FAULT;

  assign mode = oc_response[`RESP_MODE_HI:`RESP_MODE_LO];
  assign retry_set = oc_response[`RESP_RETRY_HI:`RESP_RETRY_LO];

  assign wr_clear_faults = WR_STB & (CMD_CODE == `CMD_CLEAR_FAULTS);
  assign wr_status_clear = WR_STB & (CMD_CODE == `CMD_STATUS_CURRENT) &
                           WR_DATA[`STATUS_OC_BIT];
  assign fault_clear = wr_clear_faults | wr_status_clear;

  // only a running output can be over current
  assign oc_event = oc_now & ((state == `ST_RUN) | (state == `ST_DELAY));

  // =====================================================================
  // delay timer: fault-ride interval or restart spacing, by state
  oc_delay_timer u_timer (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .load(timer_load),
    .exponent(oc_response[`RESP_TIME_HI:`RESP_TIME_LO]),
    .unit_cycles(time_unit),
    .busy(timer_busy),
    .done(timer_done)
  );

  // =====================================================================
  // retry decision: may another restart be tried after this shutdown
  function may_retry;
    input [2:0] setting;
    input [2:0] done_cnt;
    begin
      if (setting == `RETRY_FOREVER) begin
        may_retry = 1'b1;
      end else if (setting == `RETRY_NONE) begin
        may_retry = 1'b0;
      end else begin
        may_retry = (done_cnt < setting);
      end
    end
  endfunction

  // =====================================================================
  // next-state logic of the fault controller
  always @* begin
    next_state = state;
    timer_load = 1'b0;
    count_retry = 1'b0;
    clear_retry = 1'b0;
    case (state)
      `ST_OFF: begin
        // fresh start: the retry budget is full again
        clear_retry = 1'b1;
        if (enabled) begin
          next_state = `ST_RUN;
        end
      end
      `ST_RUN: begin
        if (!enabled) begin
          next_state = `ST_OFF;
        end else if (oc_now) begin
          case (mode)
            `MODE_IGNORE: begin
              next_state = `ST_RUN;
            end
            `MODE_COND_CC: begin
              if (vout_low) begin
                // shutdown: a retry waits one interval before it starts
                next_state = may_retry(retry_set, retry_cnt) ? `ST_WAIT : `ST_LATCHED;
                timer_load = 1'b1;
              end
            end
            `MODE_DELAY_CC: begin
              next_state = `ST_DELAY;
              timer_load = 1'b1;
            end
            default: begin
              next_state = may_retry(retry_set, retry_cnt) ? `ST_WAIT : `ST_LATCHED;
              timer_load = 1'b1;
            end
          endcase
        end else if (probation && timer_done) begin
          // one full interval with no over-current: the restart worked
          clear_retry = 1'b1;
        end
      end
      `ST_DELAY: begin
        if (!enabled) begin
          next_state = `ST_OFF;
        end else if (timer_done) begin
          if (oc_now) begin
            // still limiting at the end of the ride time
            next_state = may_retry(retry_set, retry_cnt) ? `ST_WAIT : `ST_LATCHED;
            timer_load = 1'b1;
          end else begin
            next_state = `ST_RUN;
          end
        end
      end
      `ST_WAIT: begin
        if (!enabled) begin
          next_state = `ST_OFF;
        end else if (fault_clear) begin
          next_state = `ST_OFF;
        end else if (timer_done || !timer_busy) begin
          next_state = `ST_RUN;
          count_retry = 1'b1;
          timer_load = 1'b1;
        end
      end
      `ST_LATCHED: begin
        // stays off until cleared; off-on and bias loss also clear it
        if (!enabled || fault_clear) begin
          next_state = `ST_OFF;
        end
      end
      default: begin
        next_state = `ST_OFF;
      end
    endcase
  end

  // =====================================================================
  // controller state, retry counter and output controls
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= `ST_OFF;
      retry_cnt <= `RST_RETRY_CNT;
      probation <= 1'b0;
      OUTPUT_EN <= 1'b0;
      CC_LIMIT_EN <= 1'b0;
    end else begin
      state <= next_state;
      if (clear_retry || fault_clear) begin
        retry_cnt <= `RST_RETRY_CNT;
      end else if (count_retry && retry_set != `RETRY_FOREVER) begin
        // the continuous setting never counts, so it can never run out
        retry_cnt <= retry_cnt + `COUNT_ONE;
      end
      // probation runs from a restart until a clean interval or a new fault
      if (count_retry) begin
        probation <= 1'b1;
      end else if (clear_retry || next_state != `ST_RUN) begin
        probation <= 1'b0;
      end
      OUTPUT_EN <= (next_state == `ST_RUN) | (next_state == `ST_DELAY);
      // brickwall limiting while the sensor is over the limit
      CC_LIMIT_EN <= oc_now & ((next_state == `ST_RUN) | (next_state == `ST_DELAY));
    end
  end

  // =====================================================================
  // status flag and host alert: a new fault wins over a clear in the same cycle
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      OC_FAULT_FLAG <= 1'b0;
      ALERT_N <= 1'b1;
    end else begin
      if (oc_event) begin
        OC_FAULT_FLAG <= 1'b1;
        ALERT_N <= 1'b0;
      end else if (fault_clear) begin
        OC_FAULT_FLAG <= 1'b0;
        ALERT_N <= 1'b1;
      end
    end
  end

  // =====================================================================
  // command writes: limit word, response byte, time unit word
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      OC_LIMIT <= `RST_OC_LIMIT;
      oc_response <= `RST_OC_RESPONSE;
      time_unit <= `RST_TIME_UNIT;
    end else if (WR_STB) begin
      case (CMD_CODE)
        `CMD_OC_LIMIT: begin
          OC_LIMIT <= WR_DATA;
        end
        `CMD_OC_RESPONSE: begin
          oc_response <= WR_DATA[7:0];
        end
        `CMD_TIME_UNIT: begin
          time_unit <= WR_DATA;
        end
        default: begin
          // other codes store nothing here
          OC_LIMIT <= OC_LIMIT;
        end
      endcase
    end
  end

  // =====================================================================
  // command reads: answer one cycle after the strobe, unknown codes read zero
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_DATA <= `RST_WORD;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_STB;
      if (RD_STB) begin
        case (CMD_CODE)
          `CMD_OC_LIMIT: begin
            RD_DATA <= OC_LIMIT;
          end
          `CMD_OC_RESPONSE: begin
            RD_DATA <= {`RST_BYTE, oc_response};
          end
          `CMD_TIME_UNIT: begin
            RD_DATA <= time_unit;
          end
          `CMD_STATUS_CURRENT: begin
            RD_DATA <= {`RST_BYTE, OC_FAULT_FLAG, 7'h00};
          end
          default: begin
            RD_DATA <= `RST_WORD;
          end
        endcase
      end
    end
  end

endmodule // oc_fault_response

// file: hdl/pin_sync3.v
// Purpose: three-stage synchroniser for asynchronous pin levels
// Assumes: inputs change slowly compared with the system clock
// Notes:   the output rises only when stages two and three are both high, and falls as soon as they disagree
`timescale 1ns/1ns

// =====================================================================
// pin synchroniser
module pin_sync3 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level
);

  reg [WIDTH-1:0] stage1; // metastability catcher, read by stage2 only
  reg [WIDTH-1:0] stage2; // first settled copy
  reg [WIDTH-1:0] stage3; // second settled copy

  // shift chain plus filter; a bit rises only once high for two edges and falls on the first disagreement
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= (stage2 & stage3) | (level & ~(stage2 ^ stage3));
    end
  end

endmodule // pin_sync3

// file: verification/oc_fault_response_properties.sv
// Purpose: port-level checks of the over-current fault responder
// Assumes: one clock domain, asynchronous active-high reset
// Notes: pins lag 3-4 cycles through the synchroniser, so bounds allow for it
`timescale 1ns/1ns
`include "oc_fault_regs.vh"

// =====================================================================
// port checker
module oc_fault_response_properties (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire [7:0] CMD_CODE,
  input wire [15:0] WR_DATA,
  input wire WR_STB,
  input wire RD_STB,
  input wire [15:0] RD_DATA,
  input wire RD_VALID,
  input wire OC_DETECT,
  input wire VOUT_BELOW_LV,
  input wire CTRL_ON,
  input wire BIAS_OK,
  input wire OPERATION_ON,
  input wire OTHER_FAULT,
  input wire OUTPUT_EN,
  input wire CC_LIMIT_EN,
  input wire [15:0] OC_LIMIT,
  input wire OC_FAULT_FLAG,
  input wire ALERT_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // codes that answer reads with real data
  wire rd_known = (CMD_CODE == `CMD_OC_LIMIT) || (CMD_CODE == `CMD_OC_RESPONSE) ||
    (CMD_CODE == `CMD_TIME_UNIT) || (CMD_CODE == `CMD_STATUS_CURRENT);
  // host actions allowed to drop the sticky flag
  wire flag_clr = WR_STB && ((CMD_CODE == `CMD_CLEAR_FAULTS) ||
    ((CMD_CODE == `CMD_STATUS_CURRENT) && WR_DATA[`STATUS_OC_BIT]));
  // all on-conditions together
  wire enabled = CTRL_ON && OPERATION_ON && BIAS_OK && !OTHER_FAULT;

  // =====================================================================
  // command port
  read_answer_a: assert property (RD_STB |=> RD_VALID) else $error("read not answered");
  answer_cause_a: assert property (RD_VALID |-> $past(RD_STB)) else $error("stray answer");
  unknown_read_a: assert property (RD_STB && !rd_known |=> RD_DATA == 16'h0000)
    else $error("unknown read not zero");
  limit_write_a: assert property (WR_STB && CMD_CODE == `CMD_OC_LIMIT |=>
    OC_LIMIT == $past(WR_DATA)) else $error("limit word not written");

  // =====================================================================
  // fault reporting and output control
  flag_sticky_a: assert property (OC_FAULT_FLAG && !flag_clr |=> OC_FAULT_FLAG)
    else $error("flag dropped without clear");
  flag_on_fault_a: assert property ((OC_DETECT && OUTPUT_EN)[*8] |-> OC_FAULT_FLAG)
    else $error("fault not flagged");
  alert_set_a: assert property (OC_FAULT_FLAG[*2] |-> !ALERT_N)
    else $error("host not alerted");
  alert_idle_a: assert property (!OC_FAULT_FLAG[*2] |-> ALERT_N) else $error("spurious alert");
  disable_off_a: assert property ((!enabled)[*8] |-> !OUTPUT_EN)
    else $error("output on while disabled");
  enable_cause_a: assert property ($rose(OUTPUT_EN) |-> $past(enabled))
    else $error("output rose without enable");
  limit_off_a: assert property ((!OUTPUT_EN)[*2] |-> !CC_LIMIT_EN)
    else $error("limiting with output off");

  // main scenarios seen
  cover property ($rose(CC_LIMIT_EN));
  cover property ($fell(OUTPUT_EN) && OC_FAULT_FLAG);
  cover property ($rose(OUTPUT_EN) && OC_FAULT_FLAG);
endmodule // oc_fault_response_properties

bind oc_fault_response oc_fault_response_properties u_props (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CMD_CODE(CMD_CODE), .WR_DATA(WR_DATA),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .OC_DETECT(OC_DETECT), .VOUT_BELOW_LV(VOUT_BELOW_LV), .CTRL_ON(CTRL_ON),
  .BIAS_OK(BIAS_OK), .OPERATION_ON(OPERATION_ON), .OTHER_FAULT(OTHER_FAULT),
  .OUTPUT_EN(OUTPUT_EN), .CC_LIMIT_EN(CC_LIMIT_EN), .OC_LIMIT(OC_LIMIT),
  .OC_FAULT_FLAG(OC_FAULT_FLAG), .ALERT_N(ALERT_N)
);

// file: verification/oc_host_model.sv
// Purpose: host side of the command port, one command per strobe
// Assumes: strobes are one-cycle pulses taken at a rising edge
// Notes: idle lines show inverted data so stale values are never trusted
`timescale 1ns/1ns

// =====================================================================
// host model
module oc_host_model (
  input wire clk,
  output reg [7:0] cmd_code,
  output reg [15:0] wr_data,
  output reg wr_stb,
  output reg rd_stb,
  input wire [15:0] rd_data,
  input wire rd_valid
);
  // quiet bus at time zero
  initial begin
    cmd_code = 8'h00;
    wr_data = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // one write; a clear command is just a write of its code
  task wr(input [7:0] code, input [15:0] data);
    begin
      @(posedge clk);
      #1;
      cmd_code = code;
      wr_data = data;
      wr_stb = 1'b1;
      @(posedge clk);
      #1;
      wr_stb = 1'b0;
      cmd_code = ~cmd_code;
      wr_data = ~wr_data;
    end
  endtask

  // one read; ok stays low if no answer within five edges
  task rd(input [7:0] code, output [15:0] data, output ok);
    integer i;
    begin
      ok = 1'b0;
      data = 16'h0000;
      @(posedge clk);
      #1;
      cmd_code = code;
      rd_stb = 1'b1;
      @(posedge clk);
      #1;
      rd_stb = 1'b0;
      cmd_code = ~cmd_code;
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end
      for (i = 0; i < 4 && !ok; i = i + 1) begin
        @(posedge clk);
        if (rd_valid === 1'b1) begin
          ok = 1'b1;
          data = rd_data;
        end
      end
    end
  endtask
endmodule // oc_host_model

// file: verification/tb_top.sv
// Purpose: self-checking bench for the over-current fault responder
// Assumes: time unit register set to a short length to keep runs brief
// Notes: random limit words and timing fields from a fixed xorshift seed
`timescale 1ns/1ns
`include "oc_fault_regs.vh"

// =====================================================================
// bench top
module tb_top;
  localparam integer UNIT = 4; // cycles per delay unit written to the timer
  reg CLK_SYS = 1'b0;
  reg SYS_RST = 1'b1;
  reg OC_DETECT = 1'b0, VOUT_BELOW_LV = 1'b0, CTRL_ON = 1'b0, BIAS_OK = 1'b0;
  reg OPERATION_ON = 1'b0, OTHER_FAULT = 1'b0;
  wire [7:0] CMD_CODE;
  wire [15:0] WR_DATA, RD_DATA, OC_LIMIT;
  wire WR_STB, RD_STB, RD_VALID, OUTPUT_EN, CC_LIMIT_EN, OC_FAULT_FLAG, ALERT_N;
  integer mismatches = 0, comparisons = 0, n, g, r, t, k;
  reg [31:0] seed = 32'h01aa;
  reg [15:0] rdv, resp;
  reg ok;
  always #5 CLK_SYS = ~CLK_SYS;

  oc_fault_response u_dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CMD_CODE(CMD_CODE),
    .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID), .OC_DETECT(OC_DETECT), .VOUT_BELOW_LV(VOUT_BELOW_LV),
    .CTRL_ON(CTRL_ON), .BIAS_OK(BIAS_OK), .OPERATION_ON(OPERATION_ON),
    .OTHER_FAULT(OTHER_FAULT), .OUTPUT_EN(OUTPUT_EN), .CC_LIMIT_EN(CC_LIMIT_EN),
    .OC_LIMIT(OC_LIMIT), .OC_FAULT_FLAG(OC_FAULT_FLAG), .ALERT_N(ALERT_N));
  oc_host_model u_host (.clk(CLK_SYS), .cmd_code(CMD_CODE), .wr_data(WR_DATA),
    .wr_stb(WR_STB), .rd_stb(RD_STB), .rd_data(RD_DATA), .rd_valid(RD_VALID));

  // =====================================================================
  // helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // restart spacing in cycles for a timing field value: 2^n units
  function integer span(input integer tf);
    begin
      span = UNIT << tf;
    end
  endfunction
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task check(input [63:0] what, input [15:0] exp, input [15:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // inputs always move one ns after the edge
  task tick(input integer c);
    begin
      repeat (c) @(posedge CLK_SYS);
      #1;
    end
  endtask
  task rchk(input [7:0] code, input [15:0] exp);
    begin
      u_host.rd(code, rdv, ok);
      check("rd_valid", 16'h0001, {15'h0000, ok});
      check("rd_data", exp, rdv);
    end
  endtask
  // bounded wait for an output level; a timeout ends the run
  task wait_out(input lvl, input integer c);
    integer j;
    begin
      for (j = 0; j < c && OUTPUT_EN !== lvl; j = j + 1) tick(1);
      check("out_en", {15'h0000, lvl}, {15'h0000, OUTPUT_EN});
      if (OUTPUT_EN !== lvl) complete_run;
    end
  endtask
  // count restarts and the off time before the first one
  task watch(input integer c, output integer rises, output integer gap);
    integer j, low;
    reg prev;
    begin
      rises = 0;
      gap = -1;
      low = 0;
      prev = OUTPUT_EN;
      for (j = 0; j < c; j = j + 1) begin
        tick(1);
        if (OUTPUT_EN === 1'b1 && prev === 1'b0) begin
          rises = rises + 1;
          if (gap < 0) gap = low;
        end
        low = (OUTPUT_EN === 1'b0) ? low + 1 : 0;
        prev = OUTPUT_EN;
      end
    end
  endtask
  // latched fault left by off-then-on of the control pin
  task recover;
    begin
      OC_DETECT = 1'b0;
      VOUT_BELOW_LV = 1'b0;
      CTRL_ON = 1'b0;
      // the off level is seen three edges after it is driven; the pin synchroniser falls on the first disagreement
      tick(8);
      wait_out(1'b0, 20);
      CTRL_ON = 1'b1;
      wait_out(1'b1, 30);
    end
  endtask

  // =====================================================================
  // main sequence
  initial begin
    tick(10);
    SYS_RST = 1'b0;
    tick(2);
    rchk(`CMD_OC_LIMIT, 16'h0000);
    rchk(`CMD_OC_RESPONSE, 16'h00c0);
    rchk(`CMD_TIME_UNIT, 16'h0064);
    rchk(8'h55, 16'h0000);
    seed = xs(seed);
    u_host.wr(`CMD_OC_LIMIT, seed[15:0]);
    rchk(`CMD_OC_LIMIT, seed[15:0]);
    check("oc_limit", seed[15:0], OC_LIMIT);
    u_host.wr(`CMD_TIME_UNIT, UNIT);
    rchk(`CMD_TIME_UNIT, UNIT);
    CTRL_ON = 1'b1;
    OPERATION_ON = 1'b1;
    BIAS_OK = 1'b1;
    wait_out(1'b1, 30);
    // ignore mode: keep running in current limit
    u_host.wr(`CMD_OC_RESPONSE, 16'h0000);
    OC_DETECT = 1'b1;
    tick(12);
    check("cc_en", 16'h0001, CC_LIMIT_EN);
    check("out_en", 16'h0001, OUTPUT_EN);
    rchk(`CMD_STATUS_CURRENT, 16'h0080);
    check("status", 16'h0001, rdv[`STATUS_OC_BIT]);
    check("alert_n", 16'h0000, ALERT_N);
    OC_DETECT = 1'b0;
    tick(8);
    u_host.wr(`CMD_STATUS_CURRENT, 16'h0080);
    tick(2);
    check("flag", 16'h0000, OC_FAULT_FLAG);
    check("alert_n", 16'h0001, ALERT_N);
    // conditioned mode: only a low output voltage shuts down
    u_host.wr(`CMD_OC_RESPONSE, {8'h00, `MODE_COND_CC, 6'h00});
    OC_DETECT = 1'b1;
    tick(12);
    check("out_en", 16'h0001, OUTPUT_EN);
    check("cc_en", 16'h0001, CC_LIMIT_EN);
    VOUT_BELOW_LV = 1'b1;
    wait_out(1'b0, 12);
    recover;
    // delayed mode: a short fault rides through, a long one trips
    u_host.wr(`CMD_OC_RESPONSE, {8'h00, `MODE_DELAY_CC, 6'h02});
    OC_DETECT = 1'b1;
    tick(6);
    OC_DETECT = 1'b0;
    tick(30);
    check("out_en", 16'h0001, OUTPUT_EN);
    OC_DETECT = 1'b1;
    tick(12);
    check("cc_en", 16'h0001, CC_LIMIT_EN);
    wait_out(1'b0, 40);
    recover;
    // shutdown mode over retry codes 0, 1, 2, 7 and 1 again
    for (k = 0; k < 5; k = k + 1) begin
      r = (k == 4) ? 1 : ((k == 3) ? 7 : k);
      seed = xs(seed);
      t = seed % 3;
      resp = {8'h00, `MODE_SHUTDOWN, r[2:0], t[2:0]};
      u_host.wr(`CMD_OC_RESPONSE, resp);
      rchk(`CMD_OC_RESPONSE, resp);
      u_host.wr(`CMD_CLEAR_FAULTS, 16'h0000);
      tick(2);
      check("flag", 16'h0000, OC_FAULT_FLAG);
      OC_DETECT = 1'b1;
      watch(10 * ((UNIT << t) + 10), n, g);
      if (r == 7) check("endless", 16'h0001, n > 6);
      else check("restarts", r[15:0], n[15:0]);
      if (r != 0) begin
        check("spacing", 16'h0001, g >= span(t) - 1 && g <= span(t) + 4);
      end
      check("flag", 16'h0001, OC_FAULT_FLAG);
      check("alert_n", 16'h0000, ALERT_N);
      OC_DETECT = 1'b0;
      if (k == 3) OTHER_FAULT = 1'b1;
      else CTRL_ON = 1'b0;
      wait_out(1'b0, 20);
      watch(4 * (UNIT << t) + 20, n, g);
      check("off_hold", 16'h0000, n[15:0]);
      OTHER_FAULT = 1'b0;
      CTRL_ON = 1'b1;
      wait_out(1'b1, 30);
    end
    // a clean interval after a restart refills the retry budget
    u_host.wr(`CMD_OC_RESPONSE, {8'h00, `MODE_SHUTDOWN, 3'h1, 3'h2});
    OC_DETECT = 1'b1;
    wait_out(1'b0, 20);
    OC_DETECT = 1'b0;
    wait_out(1'b1, 40);
    tick(3 * span(2));
    OC_DETECT = 1'b1;
    watch(60, n, g);
    check("refill", 16'h0001, n[15:0]);
    complete_run;
  end
endmodule // tb_top
